/* verilog/cci_comparator_ctrl.sv */
// Control and status logic around an analog comparator: input routing,
// result synchroniser, event detection, interrupt flag and Wishbone slave.
// Assumes the analog core drives CMP_RAW asynchronously and that the
// converter and processor supply their enable and vector-taken signals.
//
// Contract
// (R1) The result bit is one when plus is above minus.
// (R2) The raw comparator output is synchronised into CLK before it reaches the result bit.
// (R3) The event-select field picks toggle, reserved, falling or rising as the trigger.
// (R4) The event flag is set whenever the synchronised result shows the selected event; the code takes no event while the disable bit is set.
// (R5) The flag clears on vector taken or a written one; a zero leaves it.
// (R6) A request needs flag, local enable and global enable.
// (R7) The disable bit removes comparator power and may be written at any time.
// (R8) Software disables the comparator interrupt before changing the disable bit.
// (R9) Software disables the comparator interrupt before rewriting the event-select field.
// (R10) Bandgap-select puts the internal reference on plus.
// (R11) Substitution with the converter off puts converter pins 0..10 on minus.
// (R12) Without substitution minus is a dedicated pin.
// (R13) Without substitution the select field picks one of six pin pairs.
// (R14) With substitution the select field picks only the plus pin.
// (R15) The hysteresis-select bit enables hysteresis, the level bit picks 20mV or 50mV.
// (R16) The result bit is read-only and every other control bit resets to zero.
// (R17) Edges compare the synchronised result with its previous value.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/10ps
`include "cci_params.svh"
module cci_comparator_ctrl (
    input  logic        CLK,
    input  logic        RST,
    input  logic        WB_CYC_I,
    input  logic        WB_STB_I,
    input  logic        WB_WE_I,
    input  logic [7:0]  WB_ADR_I,
    input  logic [3:0]  WB_SEL_I,
    input  logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic        WB_ACK_O,
    input  logic        CMP_RAW,
    input  logic        CONVERTER_ENABLE,
    input  logic [5:0]  CONVERTER_CHANNEL_CODE,
    input  logic        GLOBAL_IRQ_ENABLE,
    input  logic        VECTOR_TAKEN,
    output logic [1:0]  POS_INPUT_SEL,
    output logic [1:0]  NEG_INPUT_SEL,
    output logic [3:0]  NEG_CHANNEL_SEL,
    output logic        CMP_POWER_OFF,
    output logic        HYST_ENABLE,
    output logic        HYST_LEVEL,
    output logic        CMP_IRQ_REQ,
    output logic        IRQ
);

    // ************************************************************
    // State
    // ************************************************************
    cci_pkg::cci_bus_state_t bus_state;
    cci_pkg::cci_bus_state_t next_bus_state;
    cci_pkg::cci_ctrl_a_t    ctrl_a;
    cci_pkg::cci_ctrl_a_t    next_ctrl_a;
    cci_pkg::cci_ctrl_b_t    ctrl_b;
    cci_pkg::cci_ctrl_b_t    next_ctrl_b;
    cci_pkg::cci_route_t     route;
    logic                    cmp_event_flag;
    logic                    next_cmp_event_flag;
    logic [`CCI_STAT_W-1:0]  irq_stat;
    logic [`CCI_STAT_W-1:0]  next_irq_stat;
    logic [`CCI_STAT_W-1:0]  irq_en;
    logic [`CCI_STAT_W-1:0]  next_irq_en;
    logic                    cmp_result;
    logic                    result_prev;
    logic [31:0]             next_rdata;

    // ************************************************************
    // Bus decode
    // ************************************************************
    wire [5:0] reg_idx   = WB_ADR_I[7:2];
    wire       bus_req   = WB_CYC_I & WB_STB_I & (bus_state == cci_pkg::CCI_BUS_IDLE);
    wire       wr_lane0  = bus_req & WB_WE_I & WB_SEL_I[0];
    wire       hit_a     = reg_idx == `CCI_IDX_CSR_A;
    wire       hit_b     = reg_idx == `CCI_IDX_CSR_B;
    wire       hit_stat  = reg_idx == `CCI_IDX_IRQ_STAT;
    wire       hit_clr   = reg_idx == `CCI_IDX_IRQ_CLR;
    wire       hit_en    = reg_idx == `CCI_IDX_IRQ_EN;
    wire       wr_a      = wr_lane0 & hit_a;
    wire       wr_b      = wr_lane0 & hit_b;
    wire       wr_clr    = wr_lane0 & hit_clr;
    wire       wr_en     = wr_lane0 & hit_en;
    wire [7:0] wdat      = WB_DAT_I[7:0];

    // Ack comes one cycle after the request and drops the cycle after
    always_comb begin
        unique case (bus_state)
            cci_pkg::CCI_BUS_IDLE: begin
                next_bus_state = bus_req ? cci_pkg::CCI_BUS_ACK : cci_pkg::CCI_BUS_IDLE;
            end
            cci_pkg::CCI_BUS_ACK: begin
                next_bus_state = cci_pkg::CCI_BUS_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Result synchroniser and edge detection
    // ************************************************************
    // Raw output is high when plus is above minus in the analog core
    cci_sync u_sync (
        .clk (CLK),
        .rst (RST),
        .d   (CMP_RAW),    // R1
        .q   (cmp_result)  // R2
    );

    wire res_rise   = cmp_result & ~result_prev;  // R17
    wire res_fall   = ~cmp_result & result_prev;  // R17
    wire res_change = cmp_result ^ result_prev;   // R17

    // An unpowered comparator gives no meaningful edges, so none are taken
    wire edges_ok   = ~ctrl_a.power_off;

    logic sel_event;
    always_comb begin
        unique case (ctrl_a.event_select)
            cci_pkg::CCI_EV_TOGGLE:   sel_event = res_change;  // R3
            cci_pkg::CCI_EV_RESERVED: sel_event = 1'b0;        // R3
            cci_pkg::CCI_EV_FALL:     sel_event = res_fall;    // R3
            cci_pkg::CCI_EV_RISE:     sel_event = res_rise;    // R3
        endcase
    end

    wire event_hit  = sel_event & edges_ok;
    wire change_hit = res_change & edges_ok;

    // ************************************************************
    // Event flag
    // ************************************************************
    // A set in the same cycle as a clear wins, so no event is lost
    wire flag_clear = VECTOR_TAKEN | (wr_a & wdat[`CCI_A_FLAG]);  // R5
    assign next_cmp_event_flag = event_hit | (cmp_event_flag & ~flag_clear);  // R4

    // ************************************************************
    // Control registers
    // ************************************************************
    always_comb begin
        next_ctrl_a = ctrl_a;
        if (wr_a) begin
            next_ctrl_a.power_off             = wdat[`CCI_A_POWER_OFF];  // R7
            next_ctrl_a.bandgap_select        = wdat[`CCI_A_BANDGAP];
            next_ctrl_a.irq_enable            = wdat[`CCI_A_IRQ_EN];
            next_ctrl_a.mux_substitute_enable = wdat[`CCI_A_MUX_SUB];
            next_ctrl_a.event_select          =
                cci_pkg::cci_event_mode_t'(wdat[`CCI_A_EVSEL_HI:`CCI_A_EVSEL_LO]);
        end
    end

    always_comb begin
        next_ctrl_b = ctrl_b;
        if (wr_b) begin
            next_ctrl_b.hysteresis_select = wdat[`CCI_B_HYST_SEL];    // R15
            next_ctrl_b.hysteresis_level  = wdat[`CCI_B_HYST_LEVEL];  // R15
            next_ctrl_b.input_pair_select = wdat[`CCI_B_PAIR_HI:`CCI_B_PAIR_LO];
        end
    end

    // ************************************************************
    // Interrupt status, clear and enable
    // ************************************************************
    wire [`CCI_STAT_W-1:0] stat_set;
    wire [`CCI_STAT_W-1:0] stat_clr = wr_clr ? wdat[`CCI_STAT_W-1:0] : `CCI_STAT_RST;

    assign stat_set[`CCI_STAT_EVENT]  = event_hit;
    assign stat_set[`CCI_STAT_CHANGE] = change_hit;

    genvar gi;
    generate
        for (gi = 0; gi < `CCI_STAT_W; gi = gi + 1) begin : g_stat
            // Set beats clear in the same cycle
            assign next_irq_stat[gi] = stat_set[gi] | (irq_stat[gi] & ~stat_clr[gi]);
        end
    endgenerate

    assign next_irq_en = wr_en ? wdat[`CCI_STAT_W-1:0] : irq_en;

    // Processor request needs flag, local enable and global enable
    wire next_cmp_irq_req = next_cmp_event_flag & next_ctrl_a.irq_enable
                            & GLOBAL_IRQ_ENABLE;  // R6
    wire next_irq         = |(next_irq_stat & next_irq_en);

    // ************************************************************
    // Input routing
    // ************************************************************
    // Substitution only when the converter is switched off
    wire ctrl_b_sub_ok = CONVERTER_CHANNEL_CODE <= `CCI_CONV_CH_MAX;
    wire mux_sub   = ctrl_b_sub_ok & ctrl_a.mux_substitute_enable & ~CONVERTER_ENABLE;
    wire [2:0] sel = ctrl_b.input_pair_select;

    cci_pkg::cci_pos_src_t pin_pos;
    cci_pkg::cci_neg_src_t pin_neg;
    cci_pkg::cci_pos_src_t sub_pos;
    cci_pkg::cci_route_t   next_route;

    always_comb begin
        unique case (sel)
            3'h0: begin
                pin_pos = cci_pkg::CCI_POS_PIN0;  // R13
                pin_neg = cci_pkg::CCI_NEG_PIN1;
            end
            3'h1: begin
                pin_pos = cci_pkg::CCI_POS_PIN0;  // R13
                pin_neg = cci_pkg::CCI_NEG_PIN2;
            end
            3'h2: begin
                pin_pos = cci_pkg::CCI_POS_PIN1;  // R13
                pin_neg = cci_pkg::CCI_NEG_PIN0;
            end
            3'h3: begin
                pin_pos = cci_pkg::CCI_POS_PIN1;  // R13
                pin_neg = cci_pkg::CCI_NEG_PIN2;
            end
            3'h4: begin
                pin_pos = cci_pkg::CCI_POS_PIN2;  // R13
                pin_neg = cci_pkg::CCI_NEG_PIN0;
            end
            default: begin
                pin_pos = cci_pkg::CCI_POS_PIN2;  // R13
                pin_neg = cci_pkg::CCI_NEG_PIN1;
            end
        endcase
    end

    // Only the positive pin is chosen while minus comes from the converter
    always_comb begin
        if (sel[2]) begin
            sub_pos = cci_pkg::CCI_POS_PIN2;  // R14
        end else if (sel[1]) begin
            sub_pos = cci_pkg::CCI_POS_PIN1;  // R14
        end else begin
            sub_pos = cci_pkg::CCI_POS_PIN0;  // R14
        end
    end

    always_comb begin
        next_route.pos     = mux_sub ? sub_pos : pin_pos;
        next_route.neg     = pin_neg;                                  // R12
        next_route.channel = 4'h0;
        if (mux_sub) begin
            next_route.neg     = cci_pkg::CCI_NEG_CONV;                // R11
            next_route.channel = CONVERTER_CHANNEL_CODE[3:0];          // R11
        end
        if (ctrl_a.bandgap_select) begin
            next_route.pos = cci_pkg::CCI_POS_BANDGAP;                 // R10
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    wire [7:0] rd_a = {ctrl_a.power_off, ctrl_a.bandgap_select, cmp_result,
                       cmp_event_flag, ctrl_a.irq_enable, ctrl_a.mux_substitute_enable,
                       ctrl_a.event_select};  // R16
    wire [7:0] rd_b = {ctrl_b.hysteresis_select, ctrl_b.hysteresis_level, 3'h0,
                       ctrl_b.input_pair_select};

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_a) begin
            next_rdata[7:0] = rd_a;
        end else if (hit_b) begin
            next_rdata[7:0] = rd_b;
        end else if (hit_stat) begin
            next_rdata[`CCI_STAT_W-1:0] = irq_stat;
        end else if (hit_en) begin
            next_rdata[`CCI_STAT_W-1:0] = irq_en;
        end
    end

    // ************************************************************
    // Flip-flops
    // ************************************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bus_state <= cci_pkg::CCI_BUS_IDLE;
            WB_ACK_O  <= 1'b0;
            WB_DAT_O  <= 32'h0000_0000;
        end else begin
            bus_state <= next_bus_state;
            WB_ACK_O  <= bus_req;
            WB_DAT_O  <= (bus_req & ~WB_WE_I) ? next_rdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_a         <= cci_pkg::cci_ctrl_a_t'(`CCI_CTRL_A_RST);  // R16
            ctrl_b         <= cci_pkg::cci_ctrl_b_t'(`CCI_CTRL_B_RST);  // R16
            cmp_event_flag <= 1'b0;
            result_prev    <= 1'b0;
        end else begin
            ctrl_a         <= next_ctrl_a;
            ctrl_b         <= next_ctrl_b;
            cmp_event_flag <= next_cmp_event_flag;
            result_prev    <= cmp_result;  // R17
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_stat    <= `CCI_STAT_RST;
            irq_en      <= `CCI_STAT_RST;
            CMP_IRQ_REQ <= 1'b0;
            IRQ         <= 1'b0;
        end else begin
            irq_stat    <= next_irq_stat;
            irq_en      <= next_irq_en;
            CMP_IRQ_REQ <= next_cmp_irq_req;  // R6
            IRQ         <= next_irq;
        end
    end

    // Routing follows the register image one cycle later; power and hysteresis controls load in the same cycle as the registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            route         <= '{cci_pkg::CCI_POS_PIN0, cci_pkg::CCI_NEG_PIN1, 4'h0};
            CMP_POWER_OFF <= 1'b0;
            HYST_ENABLE   <= 1'b0;
            HYST_LEVEL    <= 1'b0;
        end else begin
            route         <= next_route;
            CMP_POWER_OFF <= next_ctrl_a.power_off;          // R7
            HYST_ENABLE   <= next_ctrl_b.hysteresis_select;  // R15
            HYST_LEVEL    <= next_ctrl_b.hysteresis_level;   // R15
        end
    end

    assign POS_INPUT_SEL   = route.pos;
    assign NEG_INPUT_SEL   = route.neg;
    assign NEG_CHANNEL_SEL = route.channel;

endmodule : cci_comparator_ctrl

/* verilog/cci_params.svh */
// Constants for the comparator control block: register indices, field
// positions, reset values and timing counts.
// Assumes a 32-bit classic Wishbone slave, one register per aligned word.
`ifndef CCI_PARAMS_SVH
`define CCI_PARAMS_SVH

// ************************************************************
// Register indices (byte address = 4 * index)
// ************************************************************
`define CCI_IDX_CSR_A       6'h08
`define CCI_IDX_CSR_B       6'h09
`define CCI_IDX_IRQ_STAT    6'h0A
`define CCI_IDX_IRQ_CLR     6'h0B
`define CCI_IDX_IRQ_EN      6'h0C

// ************************************************************
// Field positions, control/status register A
// ************************************************************
`define CCI_A_POWER_OFF     7
`define CCI_A_BANDGAP       6
`define CCI_A_RESULT        5
`define CCI_A_FLAG          4
`define CCI_A_IRQ_EN        3
`define CCI_A_MUX_SUB       2
`define CCI_A_EVSEL_HI      1
`define CCI_A_EVSEL_LO      0

// ************************************************************
// Field positions, control/status register B
// ************************************************************
`define CCI_B_HYST_SEL      7
`define CCI_B_HYST_LEVEL    6
`define CCI_B_PAIR_HI       2
`define CCI_B_PAIR_LO       0

// ************************************************************
// Interrupt status layout
// ************************************************************
`define CCI_STAT_EVENT      0
`define CCI_STAT_CHANGE     1
`define CCI_STAT_W          2

// ************************************************************
// Reset values and limits
// ************************************************************
`define CCI_CTRL_A_RST      6'h00
`define CCI_CTRL_B_RST      5'h00
`define CCI_STAT_RST        2'h0
`define CCI_CONV_CH_MAX     6'h0A
`define CCI_SYNC_STAGES     2

`endif

/* verilog/cci_pkg.sv */
// Types shared by the comparator control block.
// Assumes cci_params.svh supplies numeric constants.
package cci_pkg;

    typedef enum logic [1:0] {
        CCI_EV_TOGGLE   = 2'b00,
        CCI_EV_RESERVED = 2'b01,
        CCI_EV_FALL     = 2'b10,
        CCI_EV_RISE     = 2'b11
    } cci_event_mode_t;

    typedef enum logic [1:0] {
        CCI_POS_PIN0    = 2'b00,
        CCI_POS_PIN1    = 2'b01,
        CCI_POS_PIN2    = 2'b10,
        CCI_POS_BANDGAP = 2'b11
    } cci_pos_src_t;

    typedef enum logic [1:0] {
        CCI_NEG_PIN0    = 2'b00,
        CCI_NEG_PIN1    = 2'b01,
        CCI_NEG_PIN2    = 2'b10,
        CCI_NEG_CONV    = 2'b11
    } cci_neg_src_t;

    typedef enum logic {
        CCI_BUS_IDLE    = 1'b0,
        CCI_BUS_ACK     = 1'b1
    } cci_bus_state_t;

    typedef struct packed {
        logic            power_off;
        logic            bandgap_select;
        logic            irq_enable;
        logic            mux_substitute_enable;
        cci_event_mode_t event_select;
    } cci_ctrl_a_t;

    typedef struct packed {
        logic            hysteresis_select;
        logic            hysteresis_level;
        logic [2:0]      input_pair_select;
    } cci_ctrl_b_t;

    typedef struct packed {
        cci_pos_src_t    pos;
        cci_neg_src_t    neg;
        logic [3:0]      channel;
    } cci_route_t;

endpackage : cci_pkg

/* verilog/cci_sync.sv */
// Two-stage level synchroniser for the raw comparator output.
// Assumes the input is asynchronous to CLK.
`timescale 1ns/10ps
module cci_sync (
    input  logic clk,
    input  logic rst,
    input  logic d,
    output logic q
);
    logic meta;

    // First stage feeds the second stage only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : cci_sync

/* tb/cci_comparator_ctrl_properties.sv */
// Concurrent checks on the ports of the comparator control block.
// Assumes one clock, CLK, and the asynchronous active-high reset RST.
`timescale 1ns/10ps
module cci_comparator_ctrl_properties (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        CMP_RAW,
    input wire logic        CONVERTER_ENABLE,
    input wire logic [5:0]  CONVERTER_CHANNEL_CODE,
    input wire logic        GLOBAL_IRQ_ENABLE,
    input wire logic        VECTOR_TAKEN,
    input wire logic [1:0]  POS_INPUT_SEL,
    input wire logic [1:0]  NEG_INPUT_SEL,
    input wire logic [3:0]  NEG_CHANNEL_SEL,
    input wire logic        CMP_IRQ_REQ,
    input wire logic        IRQ
);
    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    AST_ACK_LATENCY: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack did not follow a request");
    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I) && $past(WB_STB_I))
        else $error("ack without request");
    AST_DATA_IDLE: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside ack");
    AST_IRQ_GATE: assert property (CMP_IRQ_REQ |-> $past(GLOBAL_IRQ_ENABLE))
        else $error("request without global enable");
    // Raw input quiet for four edges means no set can race the clear
    AST_VECTOR_CLEAR: assert property (VECTOR_TAKEN && $stable(CMP_RAW) && !$past(RST, 4)
        && CMP_RAW == $past(CMP_RAW, 2) && CMP_RAW == $past(CMP_RAW, 3)
        |=> !CMP_IRQ_REQ)
        else $error("vector did not clear request");
    AST_CONV_ROUTE: assert property (NEG_INPUT_SEL == 2'h3 |-> !$past(CONVERTER_ENABLE)
        && {2'h0, NEG_CHANNEL_SEL} == $past(CONVERTER_CHANNEL_CODE)
        && $past(CONVERTER_CHANNEL_CODE) <= 6'h0A)
        else $error("converter channel routed wrongly");
    AST_DEDICATED_CH: assert property (NEG_INPUT_SEL != 2'h3 |-> NEG_CHANNEL_SEL == 4'h0)
        else $error("channel shown without substitution");
    AST_PAIR_DISTINCT: assert property (NEG_INPUT_SEL != 2'h3
        |-> POS_INPUT_SEL != NEG_INPUT_SEL)
        else $error("same pin on both inputs");

    cover property (WB_ACK_O && !WB_WE_I);
    cover property ($rose(CMP_IRQ_REQ));
    cover property ($rose(IRQ));
    cover property (NEG_INPUT_SEL == 2'h3);
endmodule : cci_comparator_ctrl_properties

bind cci_comparator_ctrl cci_comparator_ctrl_properties cci_comparator_ctrl_properties_inst (.*);

/* tb/cci_analog_model.sv */
// Behavioural analog comparator with its input multiplexer.
// Assumes pin voltages in millivolts come from the bench.
`timescale 1ns/10ps
module cci_analog_model (
    input  wire logic [1:0]  POS_INPUT_SEL,
    input  wire logic [1:0]  NEG_INPUT_SEL,
    input  wire logic [3:0]  NEG_CHANNEL_SEL,
    input  wire logic        CMP_POWER_OFF,
    input  wire logic        HYST_ENABLE,
    input  wire logic        HYST_LEVEL,
    input  wire logic [11:0] pin_mv [0:2],
    input  wire logic [11:0] conv_mv [0:10],
    output logic             cmp_raw
);
    // ************************************************************
    // Input selection and comparison
    // ************************************************************
    localparam logic [11:0] BANDGAP_MV = 12'h44C;
    wire logic [11:0] pos_mv;
    wire logic [11:0] neg_mv;
    wire logic [11:0] hys_mv;

    assign pos_mv = (POS_INPUT_SEL == 2'h3) ? BANDGAP_MV : pin_mv[POS_INPUT_SEL];
    // A channel beyond the last pin reads as ground
    assign neg_mv = (NEG_INPUT_SEL != 2'h3) ? pin_mv[NEG_INPUT_SEL] :
                    (NEG_CHANNEL_SEL > 4'hA) ? 12'h000 : conv_mv[NEG_CHANNEL_SEL];
    assign hys_mv = !HYST_ENABLE ? 12'h000 : (HYST_LEVEL ? 12'h032 : 12'h014);

    initial cmp_raw = 1'b0;
    // Output keeps its state inside the hysteresis band; unpowered it sits low
    always @(pos_mv, neg_mv, hys_mv, CMP_POWER_OFF) begin
        if (CMP_POWER_OFF) begin
            cmp_raw = 1'b0;
        end else if (pos_mv > neg_mv + hys_mv) begin
            cmp_raw = 1'b1;
        end else if (pos_mv + hys_mv <= neg_mv) begin
            cmp_raw = 1'b0;
        end
    end
endmodule : cci_analog_model

/* tb/tb_top.sv */
// Self-checking bench for the comparator control block.
// Assumes the analog model closes the loop from routing outputs to CMP_RAW.
`timescale 1ns/10ps
module tb_top;
    // ************************************************************
    // Signals
    // ************************************************************
    localparam logic [15:0] POS_T = 16'hAA50;
    localparam logic [15:0] NEG_T = 16'h5489;
    logic        CLK = 1'b0, RST = 1'b1, WB_CYC_I = 1'b0, WB_STB_I = 1'b0, WB_WE_I = 1'b0;
    logic [7:0]  WB_ADR_I = 8'h00;
    logic [3:0]  WB_SEL_I = 4'hF;
    logic [31:0] WB_DAT_I = 32'h0;
    logic        CONVERTER_ENABLE = 1'b0, GLOBAL_IRQ_ENABLE = 1'b1, VECTOR_TAKEN = 1'b0;
    logic [5:0]  CONVERTER_CHANNEL_CODE = 6'h00;
    logic [11:0] pin_mv [0:2] = '{12'h064, 12'h0C8, 12'h12C};
    logic [11:0] conv_mv [0:10] = '{default: 12'h3E8};
    wire logic [31:0] WB_DAT_O;
    wire logic [1:0]  POS_INPUT_SEL, NEG_INPUT_SEL;
    wire logic [3:0]  NEG_CHANNEL_SEL;
    wire logic        WB_ACK_O, CMP_RAW, CMP_POWER_OFF, HYST_ENABLE, HYST_LEVEL;
    wire logic        CMP_IRQ_REQ, IRQ;
    int          n_fail = 0, n_compared = 0, seed = 10;
    logic [31:0] exp_q [$];
    logic [2:0]  k;
    logic [1:0]  hb;
    logic        sub, rise, fall;

    always #5 CLK = ~CLK;

    cci_comparator_ctrl cci_comparator_ctrl_inst (.*);

    cci_analog_model cci_analog_model_inst (.*, .cmp_raw(CMP_RAW));

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc_wait(input int n);
        repeat (n) @(posedge CLK);
    endtask : cyc_wait

    // Called after an edge; ack is seen before the slave drops it
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat);
        int t = 0;
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_ADR_I <= adr;
        WB_DAT_I <= {24'h000000, dat};
        do begin
            @(posedge CLK);
            t++;
        end while (WB_ACK_O !== 1'b1 && t < 20);
        if (t >= 20) begin
            n_fail++;
            end_of_test();
        end
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        @(posedge CLK);
    endtask : wb

    task automatic wb_rd(input logic [7:0] adr, input logic [7:0] exp);
        exp_q.push_back({24'h000000, exp});
        wb(1'b0, adr, 8'h00);
    endtask : wb_rd

    // Read data is taken at the edge that sees ack
    always @(posedge CLK) begin
        if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0) begin
            chk(WB_DAT_O, exp_q.pop_front());
        end
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (10) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        chk(NEG_INPUT_SEL, 2'h1);
        wb_rd(8'h20, 8'h00);
        wb_rd(8'h24, 8'h00);
        wb_rd(8'h3C, 8'h00);
        for (int i = 0; i < 36; i++) begin
            k = (i < 12) ? i[2:0] : 3'($random(seed));
            hb = 2'($random(seed));
            if (i % 12 == 0) begin
                wb(1'b1, 8'h20, (i == 12) ? 8'h04 : 8'h00);
            end
            CONVERTER_CHANNEL_CODE <= 6'(i % 12);
            CONVERTER_ENABLE <= (i >= 24);
            wb(1'b1, 8'h24, {hb, 3'h0, k});
            cyc_wait(2);
            sub = (i >= 12) && (i < 24) && (i % 12 <= 10);
            chk(NEG_INPUT_SEL, sub ? 2'h3 : NEG_T[2*k +: 2]);
            chk(NEG_CHANNEL_SEL, sub ? 4'(i % 12) : 4'h0);
            chk(POS_INPUT_SEL, sub ? (k[2] ? 2'h2 : {1'b0, k[1]}) : POS_T[2*k +: 2]);
            chk({HYST_ENABLE, HYST_LEVEL}, hb);
            wb_rd(8'h24, {hb, 3'h0, k});
        end
        wb(1'b1, 8'h20, 8'h00);
        wb(1'b1, 8'h24, 8'h00);
        wb(1'b1, 8'h30, 8'h02);
        // Mode changes with the local enable off
        for (int m = 0; m < 4; m++) begin
            rise = (m == 0) || (m == 3);
            fall = (m == 0) || (m == 2);
            wb(1'b1, 8'h20, 8'h10 | 8'(m));
            wb(1'b1, 8'h20, 8'h08 | 8'(m));
            pin_mv[0] <= 12'h1F4;
            cyc_wait(5);
            chk(CMP_IRQ_REQ, rise);
            wb_rd(8'h20, {3'h1, rise, 2'h2, 2'(m)});
            VECTOR_TAKEN <= 1'b1;
            @(posedge CLK);
            VECTOR_TAKEN <= 1'b0;
            cyc_wait(2);
            chk(CMP_IRQ_REQ, 1'b0);
            GLOBAL_IRQ_ENABLE <= 1'b0;
            pin_mv[0] <= 12'h064;
            cyc_wait(5);
            chk(CMP_IRQ_REQ, 1'b0);
            GLOBAL_IRQ_ENABLE <= 1'b1;
            wb(1'b1, 8'h20, 8'h08 | 8'(m));
            wb_rd(8'h20, {3'h0, fall, 2'h2, 2'(m)});
            chk(CMP_IRQ_REQ, fall);
            wb(1'b1, 8'h20, 8'h10 | 8'(m));
            wb_rd(8'h20, {6'h00, 2'(m)});
        end
        chk(IRQ, 1'b1);
        wb_rd(8'h28, 8'h03);
        wb(1'b1, 8'h2C, 8'h03);
        wb_rd(8'h28, 8'h00);
        chk(IRQ, 1'b0);
        wb_rd(8'h2C, 8'h00);
        wb(1'b1, 8'h30, 8'h00);
        pin_mv[0] <= 12'h1F4;
        cyc_wait(5);
        chk(IRQ, 1'b0);
        wb_rd(8'h28, 8'h03);
        wb(1'b1, 8'h20, 8'h50);
        cyc_wait(4);
        chk(POS_INPUT_SEL, 2'h3);
        wb_rd(8'h20, 8'h60);
        wb(1'b1, 8'h20, 8'h80);
        cyc_wait(4);
        chk(CMP_POWER_OFF, 1'b1);
        wb_rd(8'h20, 8'h80);
        chk(exp_q.size(), 0);
        end_of_test();
    end
endmodule : tb_top
